// *** rtl/paor_defs.svh ***
// constants for the pixel-array operand register block
`ifndef PAOR_DEFS_SVH
`define PAOR_DEFS_SVH
// register indices on the operand write/read port
`define PAOR_IDX_SRC_PITCH 3'h1
`define PAOR_IDX_DST_PTR 3'h2
`define PAOR_IDX_DST_PITCH 3'h3
`define PAOR_IDX_ORIGIN 3'h4
`define PAOR_IDX_WIN_FIRST 3'h5
`define PAOR_IDX_WIN_LAST 3'h6
`define PAOR_IDX_DIMS 3'h7
// xy field positions
`define PAOR_Y_HI 31
`define PAOR_Y_LO 16
`define PAOR_X_HI 15
`define PAOR_X_LO 0
// reset value of every operand register
`define PAOR_REG_RESET 32'h0000_0000
// pitch granularity, pixels in one word
`define PAOR_PITCH_ALIGN 32'h0000_0010
`endif

// *** rtl/paor_pkg.sv ***
// types for the pixel-array operand register block
package paor_pkg;
  // operation requested by the instruction sequencer
  typedef enum logic [2:0] {
    PAOR_OP_NONE,
    PAOR_OP_XFER_LL,
    PAOR_OP_XFER_XY,
    PAOR_OP_FILL_L,
    PAOR_OP_WIN_COMMON,
    PAOR_OP_LINE
  } paor_op_t;
  typedef enum logic [2:0] {
    PAOR_ST_IDLE,
    PAOR_ST_CONVERT,
    PAOR_ST_RUN,
    PAOR_ST_CLIP,
    PAOR_ST_LINE
  } paor_state_t;
endpackage : paor_pkg

// *** rtl/paor_conv_if.sv ***
// link between the register block and its xy-to-linear converter
`timescale 1ns/10ps
interface paor_conv_if;
  logic [31:0] xy;
  logic [31:0] base;
  logic [4:0] pitch_log2;
  logic [4:0] pix_log2;
  logic [31:0] linear;
  modport regs (output xy, output base, output pitch_log2, output pix_log2, input linear);
  modport conv (input xy, input base, input pitch_log2, input pix_log2, output linear);
endinterface : paor_conv_if

// *** rtl/paor_xy_conv.sv ***
// xy-to-linear address converter for power-of-two pitches
`timescale 1ns/10ps
`include "paor_defs.svh"
module paor_xy_conv (
  paor_conv_if.conv port_in
);
  logic [31:0] yoff;
  logic [31:0] xoff;
  // linear = base + (y << log2 pitch) + (x << log2 pixel size)
  always_comb begin
    yoff = {16'h0000, port_in.xy[`PAOR_Y_HI:`PAOR_Y_LO]} << port_in.pitch_log2;
    xoff = {16'h0000, port_in.xy[`PAOR_X_HI:`PAOR_X_LO]} << port_in.pix_log2;
  end
  assign port_in.linear = port_in.base + yoff + xoff;
endmodule : paor_xy_conv

// *** rtl/paor_regs.sv ***
// operand registers of the pixel-array engine with address update logic
`timescale 1ns/10ps
`include "paor_defs.svh"
module paor_regs (
  input wire logic clk_in,
  input wire logic nrst_in,
  // instruction register port
  input wire logic wr_en_in,
  input wire logic [2:0] wr_idx_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [2:0] rd_idx_in,
  output logic [31:0] rd_data_out,
  // operation control from the sequencer
  input wire logic start_in,
  input wire paor_pkg::paor_op_t op_in,
  input wire logic corner_x_back_in,
  input wire logic corner_y_back_in,
  input wire logic [4:0] pix_log2_in,
  input wire logic screen_origin_select_in,
  input wire logic word_step_in,
  input wire logic [31:0] word_bits_in,
  input wire logic row_done_in,
  input wire logic interrupt_in,
  input wire logic line_step_in,
  input wire logic [31:0] line_next_xy_in,
  input wire logic line_end_in,
  // results to the engine
  output logic busy_out,
  output logic move_enable_out,
  output logic clip_overflow_out,
  output logic [31:0] dest_linear_out,
  output logic [31:0] src_row_step_out,
  output logic [31:0] dst_row_step_out,
  output logic src_xy_ok_out,
  output logic pitch_align_err_out,
  output logic done_out
);
  import paor_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    paor_state_t st;
    paor_op_t op;
    logic [31:0] source_row_pitch;
    logic [31:0] dest_array_pointer;
    logic [31:0] dest_row_pitch;
    logic [31:0] xy_origin_base;
    logic [31:0] clip_window_first_corner;
    logic [31:0] clip_window_last_corner;
    logic [31:0] array_dimensions;
    logic [31:0] row_start;
    logic [15:0] rows_left;
    logic overflow;
    logic move_en;
    logic align_err;
    logic done;
  } paor_state_s_t;

  // registered copy and the value it takes at the next edge
  paor_state_s_t cur;
  paor_state_s_t next_cur;

  // one converter serves the xy transfer, the only operation that converts
  paor_conv_if conv_link ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // log2 of a power of two; otherwise the index of the highest set bit, 0 for zero
  function automatic logic [4:0] paor_log2(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : paor_log2

  function automatic logic paor_is_pow2(input logic [31:0] v);
    return (v != 32'h0000_0000) && ((v & (v - 32'h0000_0001)) == 32'h0000_0000);
  endfunction : paor_is_pow2

  function automatic logic [15:0] paor_max16(input logic [15:0] a, input logic [15:0] b);
    return (a > b) ? a : b;
  endfunction : paor_max16

  function automatic logic [15:0] paor_min16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction : paor_min16

  // x and y halves of an xy word
  function automatic logic [15:0] paor_xf(input logic [31:0] v);
    return v[`PAOR_X_HI:`PAOR_X_LO];
  endfunction : paor_xf

  function automatic logic [15:0] paor_yf(input logic [31:0] v);
    return v[`PAOR_Y_HI:`PAOR_Y_LO];
  endfunction : paor_yf

  // ----------------------------------------------------------------
  // conversion and clip arithmetic
  // ----------------------------------------------------------------
  // array, window and intersection corners
  logic [15:0] dx;
  logic [15:0] dy;
  logic [15:0] ax0;
  logic [15:0] ay0;
  logic [16:0] ax1;
  logic [16:0] ay1;
  logic [15:0] ix0;
  logic [15:0] iy0;
  logic [15:0] ix1;
  logic [15:0] iy1;
  logic hit;
  logic [31:0] corner_xy;
  logic zero_dims;

  // window corners read here and in the readback mux; in origin-select 0 first is upper left
  always_comb begin
    dx = paor_xf(cur.array_dimensions);
    dy = paor_yf(cur.array_dimensions);
    zero_dims = (dx == 16'h0000) || (dy == 16'h0000);
    ax0 = paor_xf(cur.dest_array_pointer);
    ay0 = paor_yf(cur.dest_array_pointer);
    ax1 = {1'b0, ax0} + {1'b0, dx} - 17'h0_0001;
    ay1 = {1'b0, ay0} + {1'b0, dy} - 17'h0_0001;
    // inclusive intersection of array and window
    ix0 = paor_max16(ax0, paor_xf(cur.clip_window_first_corner));
    iy0 = paor_max16(ay0, paor_yf(cur.clip_window_first_corner));
    ix1 = paor_min16(ax1[16] ? 16'hFFFF : ax1[15:0],
                     paor_xf(cur.clip_window_last_corner));
    iy1 = paor_min16(ay1[16] ? 16'hFFFF : ay1[15:0],
                     paor_yf(cur.clip_window_last_corner));
    hit = !zero_dims && (ix0 <= ix1) && (iy0 <= iy1);
    // starting corner chosen by the backward flags
    corner_xy[`PAOR_X_HI:`PAOR_X_LO] = corner_x_back_in ? ax1[15:0] : ax0;
    corner_xy[`PAOR_Y_HI:`PAOR_Y_LO] = corner_y_back_in ? ay1[15:0] : ay0;
  end

  // converter fed the corner-adjusted xy destination
  assign conv_link.xy = corner_xy;
  assign conv_link.base = cur.xy_origin_base;
  assign conv_link.pitch_log2 = paor_log2(cur.dest_row_pitch);
  assign conv_link.pix_log2 = pix_log2_in;

  paor_xy_conv u_conv (
    .port_in(conv_link.conv)
  );

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // one process so instruction writes and hardware updates never fight
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    // software loads through the register port while idle
    if (wr_en_in && cur.st == PAOR_ST_IDLE) begin
      unique case (wr_idx_in)
        `PAOR_IDX_SRC_PITCH: begin
          next_cur.source_row_pitch = wr_data_in;
        end
        `PAOR_IDX_DST_PTR: begin
          next_cur.dest_array_pointer = wr_data_in;
        end
        `PAOR_IDX_DST_PITCH: begin
          next_cur.dest_row_pitch = wr_data_in;
        end
        `PAOR_IDX_ORIGIN: begin
          next_cur.xy_origin_base = wr_data_in;
        end
        `PAOR_IDX_WIN_FIRST: begin
          next_cur.clip_window_first_corner = wr_data_in;
        end
        `PAOR_IDX_WIN_LAST: begin
          next_cur.clip_window_last_corner = wr_data_in;
        end
        `PAOR_IDX_DIMS: begin
          next_cur.array_dimensions = wr_data_in;
        end
        default: begin
          next_cur.source_row_pitch = cur.source_row_pitch;
        end
      endcase
    end

    // hardware updates; origin base and window corners never appear below
    unique case (cur.st)
      PAOR_ST_IDLE: begin
        if (start_in && op_in != PAOR_OP_NONE) begin
          next_cur.op = op_in;
          next_cur.rows_left = dy;
          next_cur.overflow = 1'b0;
          // a linear-linear transfer uses the pointer as given
          next_cur.align_err = (op_in == PAOR_OP_XFER_LL) &&
            ((cur.source_row_pitch[3:0] != 4'h0) ||
             (cur.dest_row_pitch[3:0] != 4'h0));
          // the operation decides the first busy state
          unique case (op_in)
            PAOR_OP_XFER_XY: begin
              next_cur.st = zero_dims ? PAOR_ST_IDLE : PAOR_ST_CONVERT;
              next_cur.done = zero_dims;
            end
            PAOR_OP_WIN_COMMON: begin
              next_cur.st = PAOR_ST_CLIP;
            end
            PAOR_OP_LINE: begin
              next_cur.st = PAOR_ST_LINE;
            end
            default: begin
              // linear destination stays linear, no corner adjustment
              next_cur.row_start = cur.dest_array_pointer;
              next_cur.st = zero_dims ? PAOR_ST_IDLE : PAOR_ST_RUN;
              next_cur.done = zero_dims;
            end
          endcase
        end
      end
      PAOR_ST_CONVERT: begin
        // pointer switches to linear form before any pixel moves
        next_cur.dest_array_pointer = conv_link.linear;
        next_cur.row_start = conv_link.linear;
        next_cur.st = PAOR_ST_RUN;
      end
      PAOR_ST_RUN: begin
        // interrupt ends the run ahead of any row step
        if (interrupt_in) begin
          // pointer is left at the next word to be read; a word read now still counts
          if (word_step_in) begin
            next_cur.dest_array_pointer = cur.dest_array_pointer + word_bits_in;
          end
          next_cur.st = PAOR_ST_IDLE;
        end else if (row_done_in) begin
          // step a whole row; one-row linear fill never uses the pitch
          if (cur.op == PAOR_OP_FILL_L && dy == 16'h0001) begin
            next_cur.dest_array_pointer = cur.dest_array_pointer;
          end else begin
            next_cur.row_start = cur.row_start + dst_row_step_out;
            next_cur.dest_array_pointer = cur.row_start + dst_row_step_out;
          end
          next_cur.rows_left = cur.rows_left - 16'h0001;
          if (cur.rows_left == 16'h0001) begin
            next_cur.st = PAOR_ST_IDLE;
            next_cur.done = 1'b1;
          end
        end else if (word_step_in) begin
          next_cur.dest_array_pointer = cur.dest_array_pointer + word_bits_in;
        end
      end
      PAOR_ST_CLIP: begin
        // common rectangle only: nothing is drawn
        if (hit) begin
          next_cur.dest_array_pointer = {iy0, ix0};
          // clipped size, both corners inclusive
          next_cur.array_dimensions = {16'(iy1 - iy0 + 16'h0001),
                                       16'(ix1 - ix0 + 16'h0001)};
          next_cur.overflow = 1'b1;
        end
        next_cur.st = PAOR_ST_IDLE;
        next_cur.done = 1'b1;
      end
      PAOR_ST_LINE: begin
        if (line_step_in) begin
          next_cur.dest_array_pointer = line_next_xy_in;
        end
        // an interrupt abandons the line without a completion pulse
        if (line_end_in || interrupt_in) begin
          next_cur.st = PAOR_ST_IDLE;
          next_cur.done = line_end_in;
        end
      end
      default: begin
        // unused state codes fall back to idle
        next_cur.st = PAOR_ST_IDLE;
      end
    endcase
    next_cur.move_en = (next_cur.st == PAOR_ST_RUN) || (next_cur.st == PAOR_ST_LINE);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // origin base and window corners only change by explicit writes
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // readback mux; unmapped index reads zero
  always_comb begin
    unique case (rd_idx_in)
      `PAOR_IDX_SRC_PITCH: rd_data_out = cur.source_row_pitch;
      `PAOR_IDX_DST_PTR: rd_data_out = cur.dest_array_pointer;
      `PAOR_IDX_DST_PITCH: rd_data_out = cur.dest_row_pitch;
      `PAOR_IDX_ORIGIN: rd_data_out = cur.xy_origin_base;
      `PAOR_IDX_WIN_FIRST: rd_data_out = cur.clip_window_first_corner;
      `PAOR_IDX_WIN_LAST: rd_data_out = cur.clip_window_last_corner;
      `PAOR_IDX_DIMS: rd_data_out = cur.array_dimensions;
      default: rd_data_out = `PAOR_REG_RESET;
    endcase
  end

  // status straight from the state register
  assign busy_out = (cur.st != PAOR_ST_IDLE);
  assign move_enable_out = cur.move_en;
  assign clip_overflow_out = cur.overflow;
  // operand values handed to the engine
  assign dest_linear_out = cur.dest_array_pointer;
  assign src_row_step_out = cur.source_row_pitch;
  assign dst_row_step_out = cur.dest_row_pitch;
  // xy source needs a power-of-two pitch
  assign src_xy_ok_out = paor_is_pow2(cur.source_row_pitch) &&
                         !screen_origin_select_in;
  // error and completion flags come from flip-flops
  assign pitch_align_err_out = cur.align_err;
  assign done_out = cur.done;
endmodule : paor_regs

// *** tb/paor_regs_chk.sv ***
// concurrent checks on the operand register block ports
`timescale 1ns/10ps
module paor_regs_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic wr_en_in,
  input wire logic [2:0] wr_idx_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [2:0] rd_idx_in,
  input wire logic [31:0] rd_data_out,
  input wire logic start_in,
  input wire paor_pkg::paor_op_t op_in,
  input wire logic screen_origin_select_in,
  input wire logic line_step_in,
  input wire logic [31:0] line_next_xy_in,
  input wire logic busy_out,
  input wire logic move_enable_out,
  input wire logic clip_overflow_out,
  input wire logic [31:0] dest_linear_out,
  input wire logic [31:0] src_row_step_out,
  input wire logic [31:0] dst_row_step_out,
  input wire logic src_xy_ok_out,
  input wire logic done_out
);
  import paor_pkg::*;
  // -----------------------------
  // one domain, reset mutes all
  // -----------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_take_wr;
    wr_en_in && !busy_out && wr_idx_in != 3'h0 && rd_idx_in == wr_idx_in;
  endsequence
  sequence s_start;
    start_in && !busy_out && op_in != PAOR_OP_NONE;
  endsequence
  sequence s_zero_start;
    s_start ##0 op_in == PAOR_OP_XFER_XY && rd_idx_in == 3'h7 && rd_data_out[15:0] == 16'h0;
  endsequence
  sequence s_xy_start;
    s_start ##0 op_in == PAOR_OP_XFER_XY;
  endsequence
  // one cycle in conversion, then moving unless the size was zero
  sequence s_convert_then_move;
    !move_enable_out ##1 (move_enable_out || !busy_out);
  endsequence
  // accepted writes show on the read port one cycle later
  write_vis_a: assert property (s_take_wr ##1 $stable(rd_idx_in) |-> rd_data_out == $past(wr_data_in))
    else $error("written value not read back");
  idx_zero_a: assert property (rd_idx_in == 3'h0 |-> rd_data_out == 32'h0000_0000)
    else $error("index zero not zero");
  // origin and window corners change only by an accepted write
  hold_regs_a: assert property (rd_idx_in inside {3'h4, 3'h5, 3'h6} && $stable(rd_idx_in)
    && !$past(wr_en_in && !busy_out) |-> $stable(rd_data_out))
    else $error("origin or window corner changed");
  busy_go_a: assert property (s_start |=> busy_out ^ done_out)
    else $error("start neither taken nor finished");
  move_after_a: assert property (s_xy_start |=> s_convert_then_move)
    else $error("move began without conversion cycle");
  zero_dims_a: assert property (s_zero_start |=> !move_enable_out throughout (##[0:1] done_out))
    else $error("zero size moved or never finished");
  done_idle_a: assert property (done_out |-> !busy_out ##1 !done_out)
    else $error("done not a single idle pulse");
  ovf_done_a: assert property ($rose(clip_overflow_out) |-> done_out)
    else $error("overflow set outside completion");
  dst_pitch_a: assert property (rd_idx_in == 3'h3 |-> dst_row_step_out == rd_data_out)
    else $error("dest row step differs from pitch");
  src_pitch_a: assert property (rd_idx_in == 3'h1 |-> src_row_step_out == rd_data_out
    && src_xy_ok_out == ($onehot(rd_data_out) && !screen_origin_select_in))
    else $error("source step or xy flag wrong");
  line_load_a: assert property (busy_out && line_step_in |=> dest_linear_out == $past(line_next_xy_in))
    else $error("line point not loaded");
endmodule : paor_regs_chk
bind paor_regs paor_regs_chk u_chk (.*);

// *** tb/tb.sv ***
// self-checking bench for the operand register block
`timescale 1ns/10ps
`include "paor_defs.svh"
module tb;
  import paor_pkg::*;
  logic clk_in = 1'b0, nrst_in = 1'b0, wr_en_in = 1'b0, start_in = 1'b0, rd_chk = 1'b0;
  logic corner_x_back_in = 1'b0, corner_y_back_in = 1'b0, screen_origin_select_in = 1'b0;
  logic word_step_in = 1'b0, row_done_in = 1'b0, interrupt_in = 1'b0;
  logic line_step_in = 1'b0, line_end_in = 1'b0;
  logic [2:0] wr_idx_in = 3'h0, rd_idx_in = 3'h0;
  logic [4:0] pix_log2_in = 5'h0;
  logic [31:0] wr_data_in = 32'h0, word_bits_in = 32'h0, line_next_xy_in = 32'h0;
  paor_op_t op_in = PAOR_OP_NONE;
  logic busy_out, move_enable_out, clip_overflow_out, src_xy_ok_out, pitch_align_err_out, done_out;
  logic [31:0] rd_data_out, dest_linear_out, src_row_step_out, dst_row_step_out, v, lin, base;
  logic [63:0] d;
  logic [31:0] rd_q[$];
  logic [63:0] done_q[$];
  int failures = 0, n_checks = 0, cycles = 0;
  integer seed = 32'hCB5F9E87;
  paor_regs dut (.*);
  always #25 clk_in = ~clk_in;
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask : pulse
  task automatic wr(input logic [2:0] idx, input logic [31:0] val);
    wr_en_in = 1'b1;
    wr_idx_in = idx;
    wr_data_in = val;
    rd_idx_in = idx;
    tick(1);
    wr_en_in = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [2:0] idx, input logic [31:0] e);
    rd_idx_in = idx;
    rd_chk = 1'b1;
    rd_q.push_back(e);
    tick(1);
    rd_chk = 1'b0;
    tick(1);
  endtask : rd
  task automatic go(input paor_op_t op);
    op_in = op;
    start_in = 1'b1;
    tick(1);
    start_in = 1'b0;
  endtask : go
  // -----------------------------
  // monitor and watchdog
  // -----------------------------
  always @(posedge clk_in) begin
    cycles++;
    if (rd_chk) check("rd_data_out", rd_data_out, rd_q.pop_front());
    if (done_out === 1'b1 && done_q.size() == 0) check("done_out", 32'h1, 32'h0);
    else if (done_out === 1'b1) begin
      d = done_q.pop_front();
      check("dest_linear_out", dest_linear_out & d[63:32], d[31:0]);
    end
    if (cycles > 3000) begin
      failures++;
      print_verdict();
    end
  end
  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    tick(16);
    nrst_in = 1'b1;
    for (int i = 0; i < 8; i++) rd(i[2:0], `PAOR_REG_RESET);
    for (int i = 1; i < 8; i++) begin
      v = $random(seed);
      wr(i[2:0], v);
      rd(i[2:0], v);
    end
    wr(`PAOR_IDX_SRC_PITCH, 32'h0000_0400);
    tick(1);
    check("src_xy_ok_out", src_xy_ok_out, 32'h1);
    check("src_row_step_out", src_row_step_out, 32'h0000_0400);
    screen_origin_select_in = 1'b1;
    tick(1);
    check("src_xy_ok_out", src_xy_ok_out, 32'h0);
    screen_origin_select_in = 1'b0;
    // xy transfer, three rows, word step inside row 0
    base = $random(seed) & 32'hFFFF_0000;
    v = {8'h00, 8'($random(seed)), 8'h00, 8'($random(seed))};
    lin = base + (v[31:16] << 10) + (v[15:0] << 2);
    wr(`PAOR_IDX_ORIGIN, base);
    wr(`PAOR_IDX_DST_PITCH, 32'h0000_0400);
    tick(1);
    check("dst_row_step_out", dst_row_step_out, 32'h0000_0400);
    wr(`PAOR_IDX_DIMS, 32'h0003_0005);
    wr(`PAOR_IDX_DST_PTR, v);
    pix_log2_in = 5'h02;
    word_bits_in = 32'h0000_0020;
    go(PAOR_OP_XFER_XY);
    check("busy_out", busy_out, 32'h1);
    tick(1);
    check("dest_linear_out", dest_linear_out, lin);
    check("move_enable_out", move_enable_out, 32'h1);
    pulse(word_step_in);
    check("dest_linear_out", dest_linear_out, lin + 32'h20);
    pulse(row_done_in);
    wr(`PAOR_IDX_ORIGIN, 32'h0BAD_0000);
    go(PAOR_OP_LINE);
    pulse(row_done_in);
    done_q.push_back({32'hFFFF_FFFF, lin + 32'h0C00});
    pulse(row_done_in);
    rd(`PAOR_IDX_ORIGIN, base);
    // far corner start, interrupt keeps the next word address
    wr(`PAOR_IDX_DST_PTR, v);
    corner_x_back_in = 1'b1;
    corner_y_back_in = 1'b1;
    go(PAOR_OP_XFER_XY);
    tick(1);
    check("dest_linear_out", dest_linear_out, lin + 32'h0000_0810);
    pulse(word_step_in);
    pulse(interrupt_in);
    check("dest_linear_out", dest_linear_out, lin + 32'h0000_0830);
    check("busy_out", busy_out, 32'h0);
    // linear-linear with unaligned source pitch; pointer taken as given
    wr(`PAOR_IDX_SRC_PITCH, 32'h0000_0018);
    go(PAOR_OP_XFER_LL);
    tick(1);
    check("pitch_align_err_out", pitch_align_err_out, 32'h1);
    check("src_xy_ok_out", src_xy_ok_out, 32'h0);
    check("dest_linear_out", dest_linear_out, lin + 32'h0000_0830);
    pulse(interrupt_in);
    corner_x_back_in = 1'b0;
    corner_y_back_in = 1'b0;
    // one-pixel one-row linear fill: odd pitch allowed and never applied
    wr(`PAOR_IDX_DST_PITCH, 32'h0000_0007);
    wr(`PAOR_IDX_DIMS, 32'h0001_0001);
    wr(`PAOR_IDX_DST_PTR, base);
    done_q.push_back({32'hFFFF_FFFF, base + 32'h0000_0020});
    go(PAOR_OP_FILL_L);
    check("pitch_align_err_out", pitch_align_err_out, 32'h0);
    pulse(word_step_in);
    pulse(row_done_in);
    // zero width moves nothing
    wr(`PAOR_IDX_DIMS, 32'h0003_0000);
    done_q.push_back(64'h0);
    go(PAOR_OP_XFER_XY);
    tick(2);
    check("move_enable_out", move_enable_out, 32'h0);
    check("busy_out", busy_out, 32'h0);
    // common rectangle, hit then miss
    wr(`PAOR_IDX_WIN_FIRST, 32'h0010_0020);
    wr(`PAOR_IDX_WIN_LAST, 32'h0050_0080);
    wr(`PAOR_IDX_DST_PTR, 32'h0008_0030);
    wr(`PAOR_IDX_DIMS, 32'h0020_0100);
    done_q.push_back({32'hFFFF_FFFF, 32'h0010_0030});
    go(PAOR_OP_WIN_COMMON);
    tick(1);
    check("clip_overflow_out", clip_overflow_out, 32'h1);
    rd(`PAOR_IDX_DIMS, 32'h0018_0051);
    rd(`PAOR_IDX_WIN_FIRST, 32'h0010_0020);
    rd(`PAOR_IDX_WIN_LAST, 32'h0050_0080);
    wr(`PAOR_IDX_DST_PTR, 32'h0060_0030);
    wr(`PAOR_IDX_DIMS, 32'h0004_0004);
    done_q.push_back(64'h0);
    go(PAOR_OP_WIN_COMMON);
    tick(2);
    check("clip_overflow_out", clip_overflow_out, 32'h0);
    // line draw keeps the next point
    go(PAOR_OP_LINE);
    line_next_xy_in = $random(seed);
    pulse(line_step_in);
    check("dest_linear_out", dest_linear_out, line_next_xy_in);
    done_q.push_back({32'hFFFF_FFFF, line_next_xy_in});
    pulse(line_end_in);
    tick(2);
    check("done queue", done_q.size(), 32'h0);
    print_verdict();
  end
endmodule : tb
